/* pkg/seq_ctrl_regs.svh */
// Register offsets, reset values and timing constants for the channel bank
`ifndef SEQ_CTRL_REGS_SVH
`define SEQ_CTRL_REGS_SVH

`define ADDR_DATA_PORT      8'hC5
`define ADDR_TRAN_SEL       8'hC6
`define ADDR_TRAN_OFS       8'hC7
`define ADDR_BYTE_COUNT     8'hC8
`define ADDR_FRAME_REPEAT   8'hC9
`define ADDR_REFRESH        8'hCA
`define ADDR_SCL_LOW        8'hCB
`define ADDR_SCL_HIGH       8'hCC
`define ADDR_STATUS         8'hCD

`define TRAN_SEL_MSB        5
`define TRAN_SEL_RESET      6'h00
`define TRAN_OFS_RESET      8'h00
`define FRAME_REPEAT_RESET  8'h01
`define FRAME_REPEAT_ONCE   8'h01
`define FRAME_REPEAT_LOOP   8'h00
`define REFRESH_RESET       8'h00
`define REFRESH_OFF         8'h00
`define SCL_LOW_RESET       8'h5E
`define SCL_HIGH_RESET      8'h3F
`define ZERO8               8'h00
`define INVALID_READ        8'hFF

`define STAT_BUF_ERR_BIT    0
`define STAT_FRAME_ERR_BIT  1
`define STAT_BUSY_BIT       2

`define BUF_DEPTH           4352
`define BUF_AW              13

`define REFRESH_TICK_NS     100000
`define CLK_PERIOD_NS       10
`define REFRESH_TICK_CYC    (`REFRESH_TICK_NS / `CLK_PERIOD_NS)

`endif

/* pkg/seq_ctrl_pkg.sv */
// Types shared between the channel bank and its serial engine side
package seq_ctrl_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic seq_start;
    logic seq_done;
    logic byte_ok;
  } engine_evt_t;

  typedef enum logic [1:0] {
    LOOP_IDLE,
    LOOP_RUN,
    LOOP_WAIT
  } loop_state_t;

endpackage

/* rtl/seq_ctrl_bank.sv */
// Per-channel buffer pointer, byte count and sequence loop control bank
//
// Overview of operation
// - Transaction select holds six-bit index in bits 5:0; bits 7:6 read zero.
// - Any write to transaction select clears the byte offset to zero.
// - Data port accesses auto-increment from the newly selected position.
// - Index beyond buffer sets buffer error, drops writes, returns invalid reads.
// - Offset beyond buffer sets buffer error, drops writes, returns invalid reads.
// - Auto-increment runs across transaction length into following bytes.
// - Writing zero to transaction select points at the first buffer byte.
// - Byte offset is an eight-bit zero-based index within the transaction.
// - Byte counter is read-only, eight bits, updated live.
// - Counter counts acked write bytes and all received read bytes.
// - Byte counter clears when each new sequence starts.
// - Frame repeat count is read/write, resets to 01h, reads back as written.
// - Repeat count zero loops forever with a STOP per sequence.
// - Repeat count one sends the sequence once then STOP.
// - Repeat count above one runs that many sequences, each ending in STOP.
// - Looping with trigger off uses refresh period between sequence starts.
// - Refresh period is eight bits, one count per 100 us.
// - Refresh zero disables the timer; looped sequences run back to back.
// - Repeat count one disables the refresh function entirely.
// - Refresh too short sets frame error and requests an interrupt.
// - SCL low-period register, eight bits, resets to 5Eh.
// - SCL high-period register, eight bits, resets to 3Fh.
`timescale 1ns/1ps
`include "seq_ctrl_regs.svh"

module seq_ctrl_bank
(
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // Host register port, already in this clock domain
  input  wire seq_ctrl_pkg::host_req_t   host_req,
  output logic [7:0]                     host_rdata,
  output logic                           host_rvalid,
  // Transaction base addresses derived from the length table
  input  wire logic [`BUF_AW-1:0]        tran_base,
  output logic [5:0]                     tran_base_idx,
  // Serial engine events and controls
  input  wire seq_ctrl_pkg::engine_evt_t engine_evt,
  input  wire logic                      seq_go,
  input  wire logic                      trigger_enable,
  output logic                           seq_launch,
  output logic                           chan_busy,
  output logic [7:0]                     scl_low_period,
  output logic [7:0]                     scl_high_period,
  output logic                           frame_error_irq
);

  localparam int unsigned TICK_CYC = `REFRESH_TICK_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [5:0]         tran_sel_q;
  logic [7:0]         tran_ofs_q;
  logic [`BUF_AW-1:0] ptr_q;
  logic               ptr_reload_q;
  logic [7:0]         byte_cnt_q;
  logic [7:0]         frame_rep_q;
  logic [7:0]         refresh_q;
  logic [7:0]         scl_low_q;
  logic [7:0]         scl_high_q;
  logic               buf_err_q;
  logic               frame_err_q;
  logic [7:0]         mem [`BUF_DEPTH];

  logic wr_sel;
  logic wr_ofs;
  logic rd_stat;
  logic data_wr;
  logic data_rd;
  logic [`BUF_AW:0] ptr_full;
  logic             ptr_bad;

  assign wr_sel  = host_req.wr && host_req.addr == `ADDR_TRAN_SEL;
  assign wr_ofs  = host_req.wr && host_req.addr == `ADDR_TRAN_OFS;
  assign rd_stat = host_req.rd && host_req.addr == `ADDR_STATUS;
  assign data_wr = host_req.wr && host_req.addr == `ADDR_DATA_PORT;
  assign data_rd = host_req.rd && host_req.addr == `ADDR_DATA_PORT;
  assign tran_base_idx = tran_sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction select and byte offset
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      tran_sel_q <= `TRAN_SEL_RESET;
      tran_ofs_q <= `TRAN_OFS_RESET;
    end
    else if (wr_sel)
    begin
      tran_sel_q <= host_req.wdata[`TRAN_SEL_MSB:0];
      tran_ofs_q <= `TRAN_OFS_RESET;
    end
    else if (wr_ofs)
    begin
      tran_ofs_q <= host_req.wdata;
    end
  end

  // Selected position = base of transaction plus offset, one extra bit
  // so that a sum past the buffer end is caught instead of wrapping.
  assign ptr_full = {1'b0, tran_base} + {6'h00, tran_ofs_q};

  ////////////////////////////////////////////////////////////////////////////
  // Auto-increment data pointer; reloaded the cycle after a select change
  // so the base lookup for the new index has settled.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      ptr_q        <= '0;
      ptr_reload_q <= 1'b1;
    end
    else if (wr_sel || wr_ofs)
    begin
      ptr_reload_q <= 1'b1;
    end
    else if (ptr_reload_q)
    begin
      ptr_q        <= ptr_full[`BUF_AW-1:0];
      ptr_reload_q <= 1'b0;
    end
    else if ((data_wr || data_rd) && !ptr_bad)
    begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // Out of buffer when the computed or running pointer passes the end
  always_comb
  begin
    if (ptr_reload_q)
      ptr_bad = ptr_full >= (`BUF_AW+1)'(`BUF_DEPTH);
    else
      ptr_bad = ptr_q >= `BUF_AW'(`BUF_DEPTH);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer write; dropped when out of range or the channel is running
  always_ff @(posedge clk_sys)
  begin
    if (data_wr && !ptr_bad && !ptr_reload_q && !chan_busy)
      mem[ptr_q] <= host_req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer error flag: set on any out-of-range data access, cleared by
  // reading status. A new error in the read cycle wins over the clear.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      buf_err_q <= 1'b0;
    else if ((data_wr || data_rd) && ptr_bad)
      buf_err_q <= 1'b1;
    else if (rd_stat)
      buf_err_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live byte counter
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      byte_cnt_q <= `ZERO8;
    else if (engine_evt.seq_start)
      byte_cnt_q <= `ZERO8;
    else if (engine_evt.byte_ok)
      byte_cnt_q <= byte_cnt_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain configuration registers
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      frame_rep_q <= `FRAME_REPEAT_RESET;
      refresh_q   <= `REFRESH_RESET;
      scl_low_q   <= `SCL_LOW_RESET;
      scl_high_q  <= `SCL_HIGH_RESET;
    end
    else if (host_req.wr)
    begin
      case (host_req.addr)
        `ADDR_FRAME_REPEAT: frame_rep_q <= host_req.wdata;
        `ADDR_REFRESH:      refresh_q   <= host_req.wdata;
        `ADDR_SCL_LOW:      scl_low_q   <= host_req.wdata;
        `ADDR_SCL_HIGH:     scl_high_q  <= host_req.wdata;
        default:            ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence loop control
  seq_ctrl_pkg::loop_state_t state_q;
  logic [7:0]  frames_left_q;
  logic [7:0]  period_cnt_q;
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_q;
  logic        tick;
  logic        timed;
  logic        period_up;

  // Timer active only when looping with trigger off and nonzero period
  assign timed = frame_rep_q != `FRAME_REPEAT_ONCE && !trigger_enable
                 && refresh_q != `REFRESH_OFF;
  assign tick      = tick_cnt_q == $bits(tick_cnt_q)'(TICK_CYC - 1);
  // Launch cycle masked: the free-running divider may still tick there,
  // before the restart lands, and must not count as an expired period.
  assign period_up = tick && !seq_launch
                     && period_cnt_q + 8'h01 >= refresh_q;

  // 100 us tick divider, restarted at every sequence start. The launch
  // cycle already counts as the first cycle of the period, so the
  // restart value is one. Otherwise the period would be one cycle too long.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      tick_cnt_q <= '0;
    else if (seq_launch)
      tick_cnt_q <= $bits(tick_cnt_q)'(1);
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst || seq_launch)
      period_cnt_q <= `ZERO8;
    else if (tick && !period_up)
      period_cnt_q <= period_cnt_q + 8'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_q       <= seq_ctrl_pkg::LOOP_IDLE;
      frames_left_q <= `ZERO8;
      seq_launch    <= 1'b0;
      chan_busy     <= 1'b0;
    end
    else
    begin
      seq_launch <= 1'b0;
      unique case (state_q)
        seq_ctrl_pkg::LOOP_IDLE:
          if (seq_go)
          begin
            frames_left_q <= frame_rep_q;
            seq_launch    <= 1'b1;
            chan_busy     <= 1'b1;
            state_q       <= seq_ctrl_pkg::LOOP_RUN;
          end
        seq_ctrl_pkg::LOOP_RUN:
          if (engine_evt.seq_done)
          begin
            // Engine ends every sequence with a STOP
            if (frames_left_q == `FRAME_REPEAT_ONCE)
            begin
              chan_busy <= 1'b0;
              state_q   <= seq_ctrl_pkg::LOOP_IDLE;
            end
            else
            begin
              if (frames_left_q != `FRAME_REPEAT_LOOP)
                frames_left_q <= frames_left_q - 8'h01;
              if (timed && !period_up)
                state_q <= seq_ctrl_pkg::LOOP_WAIT;
              else
                seq_launch <= 1'b1;
            end
          end
        seq_ctrl_pkg::LOOP_WAIT:
          if (period_up)
          begin
            seq_launch <= 1'b1;
            state_q    <= seq_ctrl_pkg::LOOP_RUN;
          end
      endcase
    end
  end

  // Frame error: period ran out while a timed sequence was still running
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      frame_err_q <= 1'b0;
    else if (state_q == seq_ctrl_pkg::LOOP_RUN && timed && period_up
             && !engine_evt.seq_done)
      frame_err_q <= 1'b1;
    else if (rd_stat)
      frame_err_q <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      frame_error_irq <= 1'b0;
    else
      frame_error_irq <= frame_err_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the request
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      host_rdata  <= `ZERO8;
      host_rvalid <= 1'b0;
    end
    else
    begin
      host_rvalid <= host_req.rd;
      case (host_req.addr)
        `ADDR_DATA_PORT:
          host_rdata <= (ptr_bad || ptr_reload_q) ? `INVALID_READ
                                                  : mem[ptr_q];
        `ADDR_TRAN_SEL:     host_rdata <= {2'b00, tran_sel_q};
        `ADDR_TRAN_OFS:     host_rdata <= tran_ofs_q;
        `ADDR_BYTE_COUNT:   host_rdata <= byte_cnt_q;
        `ADDR_FRAME_REPEAT: host_rdata <= frame_rep_q;
        `ADDR_REFRESH:      host_rdata <= refresh_q;
        `ADDR_SCL_LOW:      host_rdata <= scl_low_q;
        `ADDR_SCL_HIGH:     host_rdata <= scl_high_q;
        `ADDR_STATUS:
          host_rdata <= {5'b00000, chan_busy, frame_err_q, buf_err_q};
        default:            host_rdata <= `ZERO8;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      scl_low_period  <= `SCL_LOW_RESET;
      scl_high_period <= `SCL_HIGH_RESET;
    end
    else
    begin
      scl_low_period  <= scl_low_q;
      scl_high_period <= scl_high_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sel_clears_ofs: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_sel |=> tran_ofs_q == `ZERO8) else $error("offset not cleared");
  a_cnt_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    engine_evt.seq_start |=> byte_cnt_q == `ZERO8)
    else $error("byte count not cleared");
  a_cnt_incr: assert property (@(posedge clk_sys) disable iff (!nrst)
    engine_evt.byte_ok && !engine_evt.seq_start
    |=> byte_cnt_q == $past(byte_cnt_q) + 8'h01)
    else $error("byte count not advanced");
  a_once_stops: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_q == seq_ctrl_pkg::LOOP_RUN && engine_evt.seq_done
    && frames_left_q == `FRAME_REPEAT_ONCE |=> !chan_busy && !seq_launch)
    else $error("single frame did not stop");
  a_loop_forever: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_q == seq_ctrl_pkg::LOOP_RUN && engine_evt.seq_done
    && frames_left_q == `FRAME_REPEAT_LOOP && !timed |=> seq_launch)
    else $error("continuous loop stalled");
  a_buf_err_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    (data_wr || data_rd) && ptr_bad |=> buf_err_q)
    else $error("buffer error not flagged");
  a_bad_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    data_rd && ptr_bad |=> host_rdata == `INVALID_READ)
    else $error("invalid read not marked");
  a_sel_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_sel && host_req.wdata == `ZERO8 ##1 !wr_ofs && !wr_sel
    |=> ptr_q == tran_base)
    else $error("pointer not at first byte");
  a_frame_err: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_q == seq_ctrl_pkg::LOOP_RUN && timed && period_up
    && !engine_evt.seq_done |=> frame_err_q ##1 frame_error_irq)
    else $error("frame error not raised");

endmodule

/* dv/engine_model.sv */
// Behavioural serial engine and transaction base table for the bench
`timescale 1ns/1ps
`include "seq_ctrl_regs.svh"

module engine_model
(
  input  wire logic                 clk_sys,
  input  wire logic                 seq_launch,
  input  wire logic [7:0]           nbytes,
  input  wire logic [15:0]          gap,
  input  wire logic [5:0]           tran_base_idx,
  output seq_ctrl_pkg::engine_evt_t engine_evt,
  output logic [`BUF_AW-1:0]        tran_base
);
  //////////////////////////////////////////////////////////////////////////
  // Sixteen bytes a slot; last slot starts eight bytes before buffer end
  assign tran_base = (tran_base_idx == 6'h3F) ? 13'(`BUF_DEPTH - 8)
                                              : {3'h0, tran_base_idx, 4'h0};

  // One sequence per launch; gap stretches it to overrun a refresh period
  initial
  begin
    engine_evt = '0;
    forever
    begin
      @(posedge clk_sys);
      if (seq_launch === 1'b1)
      begin
        engine_evt.seq_start <= 1'b1;
        @(posedge clk_sys);
        engine_evt.seq_start <= 1'b0;
        repeat (nbytes)
        begin
          engine_evt.byte_ok <= 1'b1;
          @(posedge clk_sys);
          engine_evt.byte_ok <= 1'b0;
          @(posedge clk_sys);
        end
        repeat (gap) @(posedge clk_sys);
        engine_evt.seq_done <= 1'b1;
        @(posedge clk_sys);
        engine_evt.seq_done <= 1'b0;
      end
    end
  end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the channel buffer and sequence loop bank
`timescale 1ns/1ps
`include "seq_ctrl_regs.svh"

module testbench;
  logic                      clk_sys;
  logic                      nrst;
  seq_ctrl_pkg::host_req_t   host_req;
  logic [7:0]                host_rdata;
  logic                      host_rvalid;
  logic [`BUF_AW-1:0]        tran_base;
  logic [5:0]                tran_base_idx;
  seq_ctrl_pkg::engine_evt_t engine_evt;
  logic                      seq_go;
  logic                      trigger_enable;
  logic                      seq_launch;
  logic                      chan_busy;
  logic [7:0]                scl_low_period;
  logic [7:0]                scl_high_period;
  logic                      frame_error_irq;
  logic [7:0]                nbytes;
  logic [15:0]               gap;
  logic [7:0]                buf_q [0:19];
  logic [7:0]                idx;
  logic [7:0]                nb;
  integer                    num_errors;
  integer                    checked;
  integer                    seed;
  integer                    cyc;
  integer                    n_launch;
  integer                    t_launch;
  integer                    t_done;
  integer                    span_l;
  integer                    span_d;
  integer                    i;
  integer                    k;

  seq_ctrl_bank u_seq_ctrl_bank (.clk_sys(clk_sys), .nrst(nrst),
    .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .tran_base(tran_base),
    .tran_base_idx(tran_base_idx), .engine_evt(engine_evt),
    .seq_go(seq_go), .trigger_enable(trigger_enable),
    .seq_launch(seq_launch), .chan_busy(chan_busy),
    .scl_low_period(scl_low_period), .scl_high_period(scl_high_period),
    .frame_error_irq(frame_error_irq));

  engine_model u_engine_model (.clk_sys(clk_sys), .seq_launch(seq_launch),
    .nbytes(nbytes), .gap(gap), .tran_base_idx(tran_base_idx),
    .engine_evt(engine_evt), .tran_base(tran_base));

  //////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Cycle count, launch spacing and hang guard
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (seq_launch === 1'b1)
    begin
      n_launch = n_launch + 1;
      span_l = cyc - t_launch;
      span_d = cyc - t_done;
      t_launch = cyc;
    end
    if (engine_evt.seq_done === 1'b1)
      t_done = cyc;
    if (cyc == 100000)
    begin
      num_errors++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Every access leaves one idle cycle, so select writes settle first
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys);
    host_req <= '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    host_req.wr <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, exp);
    logic [7:0] d;
    @(negedge clk_sys);
    host_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    host_req.rd <= 1'b0;
    // Answer stands from the taking edge to the next one
    d = host_rdata;
    check("rvalid", host_rvalid, 1'b1);
    check(nm, d, exp);
  endtask

  // Program a run, start it and optionally wait for it to finish
  task automatic run(input logic [7:0] rep, rf, n, input logic [15:0] g,
                     input bit wt);
    wr(`ADDR_FRAME_REPEAT, rep);
    wr(`ADDR_REFRESH, rf);
    nbytes = n;
    gap = g;
    n_launch = 0;
    @(negedge clk_sys);
    seq_go <= 1'b1;
    @(negedge clk_sys);
    seq_go <= 1'b0;
    for (int j = 0; wt && j < 40000 && chan_busy === 1'b1; j++)
      @(negedge clk_sys);
    if (wt) check("run_done", chan_busy, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {num_errors, checked, cyc, n_launch, t_launch, t_done} = '0;
    seed = 7633;
    nrst = 1'b0;
    host_req = '0;
    seq_go = 1'b0;
    trigger_enable = 1'b0;
    nbytes = 8'h01;
    gap = 16'd1;
    repeat (10) @(negedge clk_sys);
    nrst <= 1'b1;
    // Reset values and an unmapped place
    rdc("repeat", `ADDR_FRAME_REPEAT, 8'h01);
    rdc("refresh", `ADDR_REFRESH, 8'h00);
    rdc("scl_low", `ADDR_SCL_LOW, 8'h5E);
    rdc("scl_high", `ADDR_SCL_HIGH, 8'h3F);
    rdc("count", `ADDR_BYTE_COUNT, 8'h00);
    rdc("unmapped", 8'hC0, 8'h00);
    check("scl_low_port", scl_low_period, 8'h5E);
    check("scl_high_port", scl_high_period, 8'h3F);
    wr(`ADDR_SCL_LOW, 8'h74);
    // Port copy lags the register by one cycle
    @(negedge clk_sys);
    check("scl_low_wr", scl_low_period, 8'h74);
    // Reserved select bits and offset clearing
    wr(`ADDR_TRAN_SEL, 8'hFF);
    rdc("select", `ADDR_TRAN_SEL, 8'h3F);
    check("base_idx", tran_base_idx, 6'h3F);
    wr(`ADDR_TRAN_OFS, 8'hA5);
    rdc("offset", `ADDR_TRAN_OFS, 8'hA5);
    wr(`ADDR_TRAN_SEL, 8'h01);
    rdc("offset_clr", `ADDR_TRAN_OFS, 8'h00);
    // Twenty bytes cross into the next slot; channel idle meanwhile
    for (k = 0; k < 3; k++)
    begin
      idx = (k == 0) ? 8'h00 : 8'($unsigned($random(seed)) % 63);
      wr(`ADDR_TRAN_SEL, idx);
      for (i = 0; i < 20; i++)
      begin
        buf_q[i] = 8'($random(seed));
        wr(`ADDR_DATA_PORT, buf_q[i]);
      end
      wr(`ADDR_TRAN_SEL, idx);
      for (i = 0; i < 20; i++)
        rdc("data", `ADDR_DATA_PORT, buf_q[i]);
      wr(`ADDR_TRAN_SEL, idx);
      wr(`ADDR_TRAN_OFS, 8'h11);
      rdc("data_ofs", `ADDR_DATA_PORT, buf_q[17]);
    end
    // Last slot: one byte fits, the next runs off the buffer
    wr(`ADDR_TRAN_SEL, 8'h3F);
    wr(`ADDR_TRAN_OFS, 8'h07);
    wr(`ADDR_DATA_PORT, 8'h5A);
    wr(`ADDR_DATA_PORT, 8'hC3);
    wr(`ADDR_TRAN_OFS, 8'h07);
    rdc("data_end", `ADDR_DATA_PORT, 8'h5A);
    rdc("data_out", `ADDR_DATA_PORT, `INVALID_READ);
    rdc("status_be", `ADDR_STATUS, 8'h01);
    // Single run with a slow engine: refresh timer stays off
    nb = 8'($unsigned($random(seed)) % 40 + 1);
    run(8'h01, 8'h01, nb, 16'd10050, 1'b1);
    check("launch_once", 16'(n_launch), 16'd1);
    check("irq_once", frame_error_irq, 1'b0);
    wr(`ADDR_BYTE_COUNT, 8'h77);
    rdc("count_once", `ADDR_BYTE_COUNT, nb);
    // Untimed repeats run back to back
    run(8'h03, 8'h00, nb, 16'd5, 1'b1);
    check("launch_three", 16'(n_launch), 16'd3);
    check("gap_untimed", 16'(span_d), 16'd1);
    rdc("count_rep", `ADDR_BYTE_COUNT, nb);
    rdc("repeat_rd", `ADDR_FRAME_REPEAT, 8'h03);
    // Trigger mode: refresh period ignored, repeats run back to back
    trigger_enable <= 1'b1;
    run(8'h02, 8'h01, nb, 16'd5, 1'b1);
    check("trig_launch", 16'(n_launch), 16'd2);
    check("trig_untimed", 16'(span_d), 16'd1);
    trigger_enable <= 1'b0;
    // Timed repeats, one tick of refresh period
    run(8'h02, 8'h01, nb, 16'd20, 1'b1);
    check("period", 16'(span_l), 16'(`REFRESH_TICK_CYC));
    check("irq_timed", frame_error_irq, 1'b0);
    // Sequences longer than the period
    run(8'h02, 8'h01, nb, 16'd10050, 1'b1);
    check("launch_over", 16'(n_launch), 16'd2);
    check("irq_over", frame_error_irq, 1'b1);
    rdc("status_fe", `ADDR_STATUS, 8'h02);
    // Endless loop, cut by a reset in mid-run
    run(8'h00, 8'h00, nb, 16'd5, 1'b0);
    repeat (400) @(negedge clk_sys);
    check("endless", n_launch > 3 && chan_busy === 1'b1, 1'b1);
    nrst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst <= 1'b1;
    check("busy_rst", chan_busy, 1'b0);
    rdc("repeat_rst", `ADDR_FRAME_REPEAT, 8'h01);
    stop_test();
  end
endmodule
